// ==== core/phy_power_wake_sqi_config.sv ====
// power, wake and signal quality configuration registers of one port
//
// Notes on behaviour
// RL1: low-power code moves Normal to Sleep Request
// RL2: remote wake forwarded only when enabled
// RL3: host clears unused wake and forwarding bits
// RL4: local wake detection armed after detection time
// RL5: port address read-only, matches accesses
// RL6: address is zero, straps, port index
// RL7: averaging 32 to 256 symbols, default 64
// RL8: warning limit off at 000, default A
// RL9: fail limit off at 000, default
// RL10: fail codes 010..111 give classes B..G
// RL11: bit 1 enables autonomous power-down
`timescale 1ns/1ps
`default_nettype none
module phy_power_wake_sqi_config #(
	parameter logic PORT_INDEX = 1'b0,
	parameter int WAKE_DET_CYCLES = phy_cfg_pkg::WAKE_DET_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// hardware configuration straps, address bits 3:1
	input wire logic [2:0] addr_strap_i,
	// management register port
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [4:0] req_port_addr_i,
	input wire logic [4:0] req_reg_addr_i,
	input wire logic [15:0] req_wdata_i,
	output logic addr_match_o,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	// mode and wake events from the core
	input wire logic mode_normal_i,
	input wire logic low_power_sleep_code_i,
	input wire logic remote_wake_det_i,
	input wire logic local_wake_i,
	// events to the core
	output logic sleep_request_o,
	output logic remote_wake_forward_o,
	output logic remote_wake_react_o,
	output logic local_wake_react_o,
	output logic local_wake_forward_o,
	// configuration levels to the core
	output logic autonomous_powerdown_en_o,
	output logic [4:0] port_address_o,
	output logic [8:0] quality_averaging_symbols_o,
	output logic quality_warning_en_o,
	output logic [2:0] quality_warning_limit_o,
	output logic quality_fail_en_o,
	output logic [2:0] quality_fail_limit_o
);
	// ****************************************
	// state
	// ****************************************
	logic lowpower_code_sleep_entry_en, next_lowpower_code_sleep_entry_en;
	logic autonomous_powerdown_en, next_autonomous_powerdown_en;
	logic remote_wake_forward_en, next_remote_wake_forward_en;
	logic local_wake_react_en, next_local_wake_react_en;
	logic remote_wake_react_en, next_remote_wake_react_en;
	logic local_wake_forward_en, next_local_wake_forward_en;
	logic [1:0] quality_averaging_sel, next_quality_averaging_sel;
	logic [2:0] quality_warning_limit, next_quality_warning_limit;
	logic [2:0] quality_fail_limit, next_quality_fail_limit;
	logic [2:0] strap, next_strap;
	logic strap_taken, next_strap_taken;
	logic rd_valid, next_rd_valid;
	logic [15:0] rd_data, next_rd_data;
	logic sleep_request, next_sleep_request;
	logic remote_fwd, next_remote_fwd;
	logic remote_react, next_remote_react;
	logic local_react, next_local_react;
	logic local_fwd, next_local_fwd;
	logic [4:0] port_address;
	logic [15:0] power_wake_word;
	logic [15:0] address_quality_word;
	logic hit;

	wake_arm_if arm_bus ();

	wake_arm_timer #(
		.COUNT(WAKE_DET_CYCLES)
	) u_wake_arm (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.arm(arm_bus.timer)
	);

	assign arm_bus.react_en = local_wake_react_en;

	// ****************************************
	// address and read images
	// ****************************************
	// straps are caught after reset release, never by the reset itself
	assign port_address = {1'b0, strap, PORT_INDEX}; // RL6
	assign hit = req_valid_i && (req_port_addr_i == port_address); // RL5

	always_comb
	begin
		power_wake_word = 16'h0000;
		power_wake_word[phy_cfg_pkg::LOWPOWER_SLEEP_ENTRY_BIT] = lowpower_code_sleep_entry_en;
		power_wake_word[phy_cfg_pkg::AUTO_POWERDOWN_BIT] = autonomous_powerdown_en;
		power_wake_word[phy_cfg_pkg::REMOTE_FORWARD_BIT] = remote_wake_forward_en;
		power_wake_word[phy_cfg_pkg::LOCAL_REACT_BIT] = local_wake_react_en;
		power_wake_word[phy_cfg_pkg::REMOTE_REACT_BIT] = remote_wake_react_en;
		power_wake_word[phy_cfg_pkg::LOCAL_FORWARD_BIT] = local_wake_forward_en;
		address_quality_word = 16'h0000;
		address_quality_word[phy_cfg_pkg::PORT_ADDRESS_LSB +: 5] = port_address; // RL5
		address_quality_word[phy_cfg_pkg::AVERAGING_LSB +: 2] = quality_averaging_sel;
		address_quality_word[phy_cfg_pkg::WARNING_LSB +: 3] = quality_warning_limit;
		address_quality_word[phy_cfg_pkg::FAIL_LSB +: 3] = quality_fail_limit;
	end

	// ****************************************
	// register next values
	// ****************************************
	always_comb
	begin
		next_lowpower_code_sleep_entry_en = lowpower_code_sleep_entry_en;
		next_autonomous_powerdown_en = autonomous_powerdown_en;
		next_remote_wake_forward_en = remote_wake_forward_en;
		next_local_wake_react_en = local_wake_react_en;
		next_remote_wake_react_en = remote_wake_react_en;
		next_local_wake_forward_en = local_wake_forward_en;
		next_quality_averaging_sel = quality_averaging_sel;
		next_quality_warning_limit = quality_warning_limit;
		next_quality_fail_limit = quality_fail_limit;
		next_strap = strap;
		next_strap_taken = 1'b1;
		next_rd_valid = hit && !req_write_i;
		next_rd_data = rd_data;
		if (!strap_taken)
		begin
			next_strap = addr_strap_i; // RL6
		end
		if (hit && req_write_i)
		begin
			if (req_reg_addr_i == phy_cfg_pkg::POWER_WAKE_CONFIG_ADDR)
			begin
				next_lowpower_code_sleep_entry_en =
					req_wdata_i[phy_cfg_pkg::LOWPOWER_SLEEP_ENTRY_BIT];
				next_autonomous_powerdown_en = req_wdata_i[phy_cfg_pkg::AUTO_POWERDOWN_BIT]; // RL11
				next_remote_wake_forward_en = req_wdata_i[phy_cfg_pkg::REMOTE_FORWARD_BIT];
				next_local_wake_react_en = req_wdata_i[phy_cfg_pkg::LOCAL_REACT_BIT];
				next_remote_wake_react_en = req_wdata_i[phy_cfg_pkg::REMOTE_REACT_BIT];
				next_local_wake_forward_en = req_wdata_i[phy_cfg_pkg::LOCAL_FORWARD_BIT];
			end
			else if (req_reg_addr_i == phy_cfg_pkg::ADDRESS_QUALITY_CONFIG_ADDR)
			begin
				// address field is not writable
				next_quality_averaging_sel = req_wdata_i[phy_cfg_pkg::AVERAGING_LSB +: 2]; // RL7
				next_quality_warning_limit = req_wdata_i[phy_cfg_pkg::WARNING_LSB +: 3]; // RL8
				next_quality_fail_limit = req_wdata_i[phy_cfg_pkg::FAIL_LSB +: 3]; // RL9
			end
		end
		else if (hit)
		begin
			if (req_reg_addr_i == phy_cfg_pkg::POWER_WAKE_CONFIG_ADDR)
			begin
				next_rd_data = power_wake_word;
			end
			else if (req_reg_addr_i == phy_cfg_pkg::ADDRESS_QUALITY_CONFIG_ADDR)
			begin
				next_rd_data = address_quality_word;
			end
			else
			begin
				// other registers belong to neighbouring blocks
				next_rd_data = 16'h0000;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lowpower_code_sleep_entry_en <= phy_cfg_pkg::LOWPOWER_SLEEP_ENTRY_RESET;
			autonomous_powerdown_en <= phy_cfg_pkg::AUTO_POWERDOWN_RESET;
			remote_wake_forward_en <= phy_cfg_pkg::REMOTE_FORWARD_RESET;
			local_wake_react_en <= phy_cfg_pkg::LOCAL_REACT_RESET;
			remote_wake_react_en <= phy_cfg_pkg::REMOTE_REACT_RESET;
			local_wake_forward_en <= phy_cfg_pkg::LOCAL_FORWARD_RESET;
			quality_averaging_sel <= phy_cfg_pkg::AVERAGING_RESET;
			quality_warning_limit <= phy_cfg_pkg::WARNING_RESET;
			quality_fail_limit <= phy_cfg_pkg::FAIL_RESET;
			strap <= 3'h0;
			strap_taken <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
		end
		else
		begin
			lowpower_code_sleep_entry_en <= next_lowpower_code_sleep_entry_en;
			autonomous_powerdown_en <= next_autonomous_powerdown_en;
			remote_wake_forward_en <= next_remote_wake_forward_en;
			local_wake_react_en <= next_local_wake_react_en;
			remote_wake_react_en <= next_remote_wake_react_en;
			local_wake_forward_en <= next_local_wake_forward_en;
			quality_averaging_sel <= next_quality_averaging_sel;
			quality_warning_limit <= next_quality_warning_limit;
			quality_fail_limit <= next_quality_fail_limit;
			strap <= next_strap;
			strap_taken <= next_strap_taken;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// wake and sleep events
	// ****************************************
	always_comb
	begin
		next_sleep_request = lowpower_code_sleep_entry_en && mode_normal_i &&
			low_power_sleep_code_i; // RL1
		next_remote_fwd = remote_wake_forward_en && remote_wake_det_i; // RL2
		next_remote_react = remote_wake_react_en && remote_wake_det_i;
		next_local_react = arm_bus.detect_active && local_wake_i; // RL4
		next_local_fwd = local_wake_forward_en && arm_bus.detect_active && local_wake_i;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sleep_request <= 1'b0;
			remote_fwd <= 1'b0;
			remote_react <= 1'b0;
			local_react <= 1'b0;
			local_fwd <= 1'b0;
		end
		else
		begin
			sleep_request <= next_sleep_request;
			remote_fwd <= next_remote_fwd;
			remote_react <= next_remote_react;
			local_react <= next_local_react;
			local_fwd <= next_local_fwd;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign addr_match_o = hit;
	assign rd_valid_o = rd_valid;
	assign rd_data_o = rd_data;
	assign sleep_request_o = sleep_request;
	assign remote_wake_forward_o = remote_fwd;
	assign remote_wake_react_o = remote_react;
	assign local_wake_react_o = local_react;
	assign local_wake_forward_o = local_fwd;
	assign autonomous_powerdown_en_o = autonomous_powerdown_en; // RL11
	assign port_address_o = port_address;
	// 32 shifted by the selection gives 32, 64, 128, 256
	assign quality_averaging_symbols_o =
		phy_cfg_pkg::AVERAGING_BASE_SYMBOLS << quality_averaging_sel; // RL7
	assign quality_warning_en_o = (quality_warning_limit != phy_cfg_pkg::LIMIT_DISABLED); // RL8
	assign quality_warning_limit_o = quality_warning_limit;
	assign quality_fail_en_o = (quality_fail_limit != phy_cfg_pkg::LIMIT_DISABLED); // RL9
	assign quality_fail_limit_o = quality_fail_limit; // RL10
endmodule : phy_power_wake_sqi_config
`default_nettype wire

// ==== core/phy_cfg_pkg.sv ====
// constants shared by the power, wake and signal quality configuration logic
package phy_cfg_pkg;
	// ****************************************
	// register indices on the management port
	// ****************************************
	localparam logic [4:0] POWER_WAKE_CONFIG_ADDR = 5'h12;
	localparam logic [4:0] ADDRESS_QUALITY_CONFIG_ADDR = 5'h13;

	// ****************************************
	// power_wake_config field positions
	// ****************************************
	localparam int LOWPOWER_SLEEP_ENTRY_BIT = 0;
	localparam int AUTO_POWERDOWN_BIT = 1;
	localparam int REMOTE_FORWARD_BIT = 2;
	localparam int LOCAL_REACT_BIT = 10;
	localparam int REMOTE_REACT_BIT = 11;
	localparam int LOCAL_FORWARD_BIT = 14;

	// ****************************************
	// address_quality_config field positions
	// ****************************************
	localparam int PORT_ADDRESS_LSB = 11;
	localparam int AVERAGING_LSB = 9;
	localparam int WARNING_LSB = 6;
	localparam int FAIL_LSB = 3;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic LOWPOWER_SLEEP_ENTRY_RESET = 1'b1;
	localparam logic AUTO_POWERDOWN_RESET = 1'b0;
	localparam logic REMOTE_FORWARD_RESET = 1'b0;
	localparam logic LOCAL_REACT_RESET = 1'b0;
	localparam logic REMOTE_REACT_RESET = 1'b0;
	localparam logic LOCAL_FORWARD_RESET = 1'b0;
	localparam logic [1:0] AVERAGING_RESET = 2'h1;
	localparam logic [2:0] WARNING_RESET = 3'h1;
	localparam logic [2:0] FAIL_RESET = 3'h0;
	localparam logic [2:0] LIMIT_DISABLED = 3'h0;
	localparam logic [8:0] AVERAGING_BASE_SYMBOLS = 9'h020;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	// wake detection time, fixed here at 50000 ns, 12500 cycles of the 4 ns clock
	localparam int WAKE_DET_TIME_NS = 50000;
	localparam int WAKE_DET_CYCLES = (WAKE_DET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : phy_cfg_pkg

// ==== core/wake_arm_if.sv ====
// carrier between the register logic and the local wake activation timer
`timescale 1ns/1ps
`default_nettype none
interface wake_arm_if;
	logic react_en;
	logic detect_active;
	modport ctrl (output react_en, input detect_active);
	modport timer (input react_en, output detect_active);
endinterface : wake_arm_if
`default_nettype wire

// ==== core/wake_arm_timer.sv ====
// activation delay of local wake detection after its enable is set
`timescale 1ns/1ps
`default_nettype none
module wake_arm_timer #(
	parameter int COUNT = 12500
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// control side
	wake_arm_if.timer arm
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LOAD = CW'(COUNT);

	logic [CW-1:0] remain;
	logic [CW-1:0] next_remain;
	logic en_seen;
	logic next_en_seen;

	always_comb
	begin
		next_en_seen = arm.react_en;
		next_remain = remain;
		if (!arm.react_en)
		begin
			next_remain = LOAD;
		end
		else if (!en_seen)
		begin
			next_remain = LOAD;
		end
		else if (remain != '0)
		begin
			next_remain = remain - CW'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			remain <= LOAD;
			en_seen <= 1'b0;
		end
		else
		begin
			remain <= next_remain;
			en_seen <= next_en_seen;
		end
	end

	// wakes inside the window are missed on purpose
	assign arm.detect_active = arm.react_en && en_seen && (remain == '0); // RL4
endmodule : wake_arm_timer
`default_nettype wire

// ==== testbench/phy_cfg_asserts.sv ====
// concurrent checks on the power, wake and signal quality configuration ports
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_asserts #(
	parameter logic PORT_INDEX = 1'b0
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// register port
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [4:0] req_port_addr_i,
	input wire logic addr_match_o,
	input wire logic rd_valid_o,
	// events
	input wire logic mode_normal_i,
	input wire logic low_power_sleep_code_i,
	input wire logic remote_wake_det_i,
	input wire logic local_wake_i,
	input wire logic sleep_request_o,
	input wire logic remote_wake_forward_o,
	input wire logic local_wake_react_o,
	input wire logic local_wake_forward_o,
	// configuration levels
	input wire logic [4:0] port_address_o,
	input wire logic [8:0] quality_averaging_symbols_o,
	input wire logic quality_warning_en_o,
	input wire logic [2:0] quality_warning_limit_o,
	input wire logic quality_fail_en_o,
	input wire logic [2:0] quality_fail_limit_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	a_sleep_cause: assert property (
		sleep_request_o |-> $past(low_power_sleep_code_i && mode_normal_i))
		else $error("sleep request without cause");
	a_remote_forward: assert property (
		remote_wake_forward_o |-> $past(remote_wake_det_i))
		else $error("remote forward without wake");
	a_local_cause: assert property (
		local_wake_forward_o |-> local_wake_react_o && $past(local_wake_i))
		else $error("local forward without local wake");
	a_match_rule: assert property (
		addr_match_o == (req_valid_i && req_port_addr_i == port_address_o))
		else $error("address match wrong");
	a_read_answer: assert property (
		rd_valid_o |-> $past(addr_match_o && !req_write_i))
		else $error("read answer without matched read");
	a_addr_fixed: assert property (
		port_address_o[4] == 1'b0 && port_address_o[0] == PORT_INDEX)
		else $error("port address fixed bits wrong");
	a_avg_legal: assert property (
		quality_averaging_symbols_o inside {9'h020, 9'h040, 9'h080, 9'h100})
		else $error("averaging length illegal");
	a_warn_off: assert property (
		quality_warning_en_o == (quality_warning_limit_o != 3'h0))
		else $error("warning enable wrong");
	a_fail_off: assert property (
		quality_fail_en_o == (quality_fail_limit_o != 3'h0))
		else $error("fail enable wrong");
endmodule : phy_cfg_asserts
bind phy_power_wake_sqi_config phy_cfg_asserts #(.PORT_INDEX(PORT_INDEX)) u_chk (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
	.req_write_i(req_write_i), .req_port_addr_i(req_port_addr_i), .addr_match_o(addr_match_o),
	.rd_valid_o(rd_valid_o), .mode_normal_i(mode_normal_i),
	.low_power_sleep_code_i(low_power_sleep_code_i), .remote_wake_det_i(remote_wake_det_i),
	.local_wake_i(local_wake_i), .sleep_request_o(sleep_request_o),
	.remote_wake_forward_o(remote_wake_forward_o), .local_wake_react_o(local_wake_react_o),
	.local_wake_forward_o(local_wake_forward_o), .port_address_o(port_address_o),
	.quality_averaging_symbols_o(quality_averaging_symbols_o),
	.quality_warning_en_o(quality_warning_en_o), .quality_warning_limit_o(quality_warning_limit_o),
	.quality_fail_en_o(quality_fail_en_o), .quality_fail_limit_o(quality_fail_limit_o));
`default_nettype wire

// ==== testbench/mgmt_host.sv ====
// management host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
	// clock
	input wire logic clk_i,
	// request
	output var logic valid_o,
	output var logic write_o,
	output var logic [4:0] port_o,
	output var logic [4:0] reg_o,
	output var logic [15:0] wdata_o,
	// answer
	input wire logic rvalid_i,
	input wire logic [15:0] rdata_i
);
	initial
	begin
		valid_o = 1'b0;
		write_o = 1'b0;
		port_o = 5'h00;
		reg_o = 5'h00;
		wdata_o = 16'h0000;
	end
	// register line flips after every request and write data line after a write, so a stale value can never pass for a fresh one
	task automatic wr(input logic [4:0] port, input logic [4:0] ra, input logic [15:0] data);
		@(negedge clk_i);
		valid_o = 1'b1;
		write_o = 1'b1;
		port_o = port;
		reg_o = ra;
		wdata_o = data;
		@(negedge clk_i);
		valid_o = 1'b0;
		wdata_o = ~wdata_o;
		reg_o = ~reg_o;
	endtask : wr
	task automatic rd(input logic [4:0] port, input logic [4:0] ra, output logic got,
		output logic [15:0] data);
		@(negedge clk_i);
		valid_o = 1'b1;
		write_o = 1'b0;
		port_o = port;
		reg_o = ra;
		@(negedge clk_i);
		valid_o = 1'b0;
		reg_o = ~reg_o;
		got = rvalid_i;
		data = rdata_i;
	endtask : rd
endmodule : mgmt_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the power, wake and signal quality configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [4:0] ADDR = 5'h0B;
	localparam int WAKE = 4;
	logic clk, resetn, lp, rw, lw, mode, valid, wr, match, rv, sleep, rfwd, rreact, lreact, lfwd;
	logic pd, wen, fen;
	logic [4:0] pa, ra, paddr;
	logic [15:0] wd, rdat;
	logic [8:0] avg;
	logic [2:0] wl, fl, c, f, strap;
	int fails = 0;
	int total_checks = 0;
	mgmt_host host (.clk_i(clk), .valid_o(valid), .write_o(wr), .port_o(pa), .reg_o(ra),
		.wdata_o(wd), .rvalid_i(rv), .rdata_i(rdat));
	phy_power_wake_sqi_config #(.PORT_INDEX(1'b1), .WAKE_DET_CYCLES(WAKE)) dut (
		.core_clk_i(clk), .resetn_i(resetn), .addr_strap_i(strap), .req_valid_i(valid),
		.req_write_i(wr), .req_port_addr_i(pa), .req_reg_addr_i(ra), .req_wdata_i(wd),
		.addr_match_o(match), .rd_valid_o(rv), .rd_data_o(rdat), .mode_normal_i(mode),
		.low_power_sleep_code_i(lp), .remote_wake_det_i(rw), .local_wake_i(lw),
		.sleep_request_o(sleep), .remote_wake_forward_o(rfwd), .remote_wake_react_o(rreact),
		.local_wake_react_o(lreact), .local_wake_forward_o(lfwd), .autonomous_powerdown_en_o(pd),
		.port_address_o(paddr), .quality_averaging_symbols_o(avg), .quality_warning_en_o(wen),
		.quality_warning_limit_o(wl), .quality_fail_en_o(fen), .quality_fail_limit_o(fl));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [4:0] r, input logic [15:0] exp);
		logic v;
		logic [15:0] d;
		host.rd(ADDR, r, v, d);
		chk({15'h0, v}, 16'h0001, "read answer");
		chk(d, exp, "read data");
	endtask : rc
	// inputs {lp, rw, lw}; outputs {sleep, rfwd, rreact, lreact, lfwd}
	task automatic ev(input logic [2:0] m, input logic [4:0] exp, input string what);
		@(negedge clk);
		{lp, rw, lw} = m;
		@(negedge clk);
		chk({11'h0, sleep, rfwd, rreact, lreact, lfwd}, {11'h0, exp}, what);
		{lp, rw, lw} = 3'h0;
	endtask : ev
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	initial
	begin
		#20us;
		fails++;
		results();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic v;
		logic [15:0] d;
		resetn = 1'b0;
		strap = 3'h5;
		{lp, rw, lw} = 3'h0;
		mode = 1'b1;
		repeat (10) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		repeat (2) @(posedge clk);
		rc(5'h12, 16'h0001);
		rc(5'h13, 16'h5A40);
		chk({7'h0, avg}, 16'h0040, "default averaging");
		chk({8'h0, wen, wl, fen, fl}, 16'h0090, "default limits");
		chk({15'h0, pd}, 16'h0000, "default power-down");
		rc(5'h05, 16'h0000);
		host.rd(5'h0A, 5'h12, v, d);
		chk({15'h0, v}, 16'h0000, "foreign port answered");
		$display("test reset and access done");
		ev(3'h4, 5'h10, "sleep entry");
		mode = 1'b0;
		ev(3'h4, 5'h00, "sleep outside normal");
		mode = 1'b1;
		ev(3'h2, 5'h00, "forward while off");
		host.wr(ADDR, 5'h12, 16'h0006);
		chk({15'h0, pd}, 16'h0001, "power-down on");
		ev(3'h4, 5'h00, "sleep entry off");
		ev(3'h2, 5'h08, "forward while on");
		rc(5'h12, 16'h0006);
		// react bit alone must not forward
		host.wr(ADDR, 5'h12, 16'h0800);
		ev(3'h2, 5'h04, "react without forward");
		$display("test events done");
		// address bits written as ones must not stick
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			f = 3'h7 - c;
			host.wr(ADDR, 5'h13, {5'h1F, c[1:0], c, f, 3'h7});
			rc(5'h13, {5'h0B, c[1:0], c, f, 3'h0});
			chk({7'h0, avg}, {7'h0, 9'h020 << c[1:0]}, "averaging");
			chk({8'h0, wen, wl, fen, fl}, {8'h0, c != 3'h0, c, f != 3'h0, f}, "limits");
		end
		$display("test quality fields done");
		host.wr(ADDR, 5'h12, 16'h0400);
		ev(3'h1, 5'h00, "wake inside window");
		repeat (WAKE) @(negedge clk);
		ev(3'h1, 5'h02, "wake after window");
		host.wr(ADDR, 5'h12, 16'h4400);
		ev(3'h1, 5'h03, "wake forwarded");
		host.wr(ADDR, 5'h12, 16'h0001);
		ev(3'h1, 5'h00, "wake disarmed");
		$display("test local wake done");
		// second reset with other straps; a strap move after capture must not count
		@(negedge clk);
		resetn = 1'b0;
		strap = 3'h2;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		strap = 3'h7;
		chk({11'h0, paddr}, 16'h0005, "strap capture");
		host.rd(5'h05, 5'h13, v, d);
		chk({15'h0, v}, 16'h0001, "answer at new address");
		chk(d, 16'h2A40, "reset image at new address");
		host.rd(5'h05, 5'h12, v, d);
		chk(d, 16'h0001, "power wake reset image");
		$display("test second reset done");
		results();
	end
endmodule : testbench
`default_nettype wire
